// File: rtl/cps_pkg.sv
package cps_pkg;
  localparam int PC_W = 11;
  localparam int ROM_W = 10;
  localparam int RAM_DEPTH = 32;
  localparam int RAM_AW = 5;
  localparam int NIB_W = 4;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [10:0] TEST_AREA_LO = 11'h7EA;
  localparam logic [10:0] TEST_AREA_HI = 11'h7FF;
  localparam logic [10:0] ROM_TOP_DEFAULT = 11'h7E9;
  localparam logic [4:0] RAM_FIRST_LO = 5'h00;
  localparam logic [4:0] RAM_FIRST_HI = 5'h10;
  localparam logic [4:0] RAM_LAST_LO = 5'h0F;
  localparam logic [4:0] RAM_LAST_HI = 5'h1F;
  localparam int CTRL0_TPTR_LSB = 4;
  typedef enum logic [2:0] {
    CPS_OP_NEXT,
    CPS_OP_JUMP,
    CPS_OP_CALL,
    CPS_OP_RET
  } cps_op_t;
endpackage

// File: rtl/cps_data_ram.sv
`timescale 1ns/1ps
module cps_data_ram
  import cps_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic we_i, // Nibble write
  input wire logic [RAM_AW-1:0] waddr_i, // Write index
  input wire logic [NIB_W-1:0] wdata_i, // Write data
  input wire logic ra_we_i, // Return-address byte write
  input wire logic [7:0] ra_wdata_i, // Return-address low byte
  input wire logic [RAM_AW-1:0] raddr_i, // Read index
  output logic [NIB_W-1:0] rdata_o, // Read data
  output logic [7:0] first_pair_o, // First word pair
  output logic [7:0] last_pair_o // Last word pair
);
  logic [NIB_W-1:0] mem_reg [DEPTH];

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_word
      localparam logic [RAM_AW-1:0] IDX = RAM_AW'(gi);
      wire is_first = (IDX == RAM_FIRST_LO) || (IDX == RAM_FIRST_HI);
      wire ra_lo = ra_we_i && (IDX == RAM_LAST_LO);
      wire ra_hi = ra_we_i && (IDX == RAM_LAST_HI);
      always_ff @(posedge mclk_i) begin
        // Only the first pair clears; others keep contents across reset
        if (rst_i && is_first) begin
          mem_reg[gi] <= '0;
        end else if (ra_lo) begin
          mem_reg[gi] <= ra_wdata_i[3:0];
        end else if (ra_hi) begin
          mem_reg[gi] <= ra_wdata_i[7:4];
        end else if (!rst_i && we_i && waddr_i == IDX) begin
          mem_reg[gi] <= wdata_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    rdata_o <= mem_reg[raddr_i];
  end
  assign first_pair_o = {mem_reg[RAM_FIRST_HI], mem_reg[RAM_FIRST_LO]};
  assign last_pair_o = {mem_reg[RAM_LAST_HI], mem_reg[RAM_LAST_LO]};
endmodule // cps_data_ram

// File: rtl/cps_sequencer.sv
`timescale 1ns/1ps
module cps_sequencer
  import cps_pkg::*;
#(
  parameter logic [10:0] ROM_TOP = ROM_TOP_DEFAULT
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Sync reset
  input wire logic exec_i, // One instruction executes
  input wire logic [2:0] op_i, // Sequencing operation
  input wire logic [1:0] ilen_i, // Instruction length
  input wire logic jump_taken_i, // Jump condition met
  input wire logic [PC_W-1:0] dest_i, // Operand destination
  input wire logic [PC_W-1:0] ra_i, // Return register value
  output logic [PC_W-1:0] pc_o, // Program counter
  output logic depth_o, // Call depth pointer
  output logic sys_reset_o, // Depth fault reset pulse
  output logic save_o // Save return address
);
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic depth_reg;
  logic fault_reg;

  wire is_call = exec_i && (op_i == 3'(CPS_OP_CALL));
  wire is_ret = exec_i && (op_i == 3'(CPS_OP_RET));
  wire is_jmp = exec_i && (op_i == 3'(CPS_OP_JUMP)) && jump_taken_i;
  // Second nesting level or return at depth zero resets the core
  wire fault = (is_call && depth_reg) || (is_ret && !depth_reg);
  wire [PC_W-1:0] seq_pc = pc_reg + PC_W'(ilen_i);
  wire [PC_W-1:0] raw_next = is_call ? dest_i :
                             is_ret ? ra_i :
                             is_jmp ? dest_i :
                             exec_i ? seq_pc : pc_reg;
  // Unpopulated and test area fold back to zero
  wire bad_area = (raw_next > ROM_TOP) ||
                  (raw_next >= TEST_AREA_LO && raw_next <= TEST_AREA_HI);

  assign pc_next = (fault || bad_area) ? PC_RESET : raw_next;
  assign save_o = is_call && !fault;

  always_ff @(posedge mclk_i) begin
    if (rst_i || fault_reg) begin
      pc_reg <= PC_RESET;
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Depth changes only by call/return and reset; no direct write port exists
  always_ff @(posedge mclk_i) begin
    if (rst_i || fault_reg) begin
      depth_reg <= 1'b0;
    end else if (is_call && !fault) begin
      depth_reg <= 1'b1;
    end else if (is_ret && !fault) begin
      depth_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault && !fault_reg;
    end
  end

  assign pc_o = pc_reg;
  assign depth_o = depth_reg;
  assign sys_reset_o = fault_reg;

  property p_reset_pc;
    @(posedge mclk_i) rst_i |=> pc_reg == PC_RESET;
  endproperty
  a_reset_pc: assert property (p_reset_pc) else $error("pc not zero after reset");
  property p_call_pc;
    @(posedge mclk_i) disable iff (rst_i)
      (save_o && !fault_reg && !bad_area) |=> pc_reg == $past(dest_i);
  endproperty
  a_call_pc: assert property (p_call_pc) else $error("call did not load destination");
  property p_fault_clear;
    @(posedge mclk_i) disable iff (rst_i)
      (fault && !fault_reg) |=> sys_reset_o ##1 (pc_reg == PC_RESET && !depth_reg);
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("depth fault did not reset");
  property p_depth_call;
    @(posedge mclk_i) disable iff (rst_i) (save_o && !fault_reg) |=> depth_reg;
  endproperty
  a_depth_call: assert property (p_depth_call) else $error("depth did not rise on call");
  property p_depth_stable;
    @(posedge mclk_i) disable iff (rst_i)
      (!is_call && !is_ret && !fault_reg) |=> $stable(depth_reg);
  endproperty
  a_depth_stable: assert property (p_depth_stable) else $error("depth moved without call");
  property p_no_test_area;
    @(posedge mclk_i) disable iff (rst_i) !(pc_reg >= TEST_AREA_LO);
  endproperty
  a_no_test_area: assert property (p_no_test_area) else $error("pc in test area");
endmodule // cps_sequencer

// File: rtl/cps_program_core.sv
`timescale 1ns/1ps
module cps_program_core
  import cps_pkg::*;
#(
  parameter logic [10:0] ROM_TOP = ROM_TOP_DEFAULT
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Sync reset, active high
  input wire logic exec_i, // Instruction executes this cycle
  input wire logic [2:0] op_i, // Sequencing op (cps_op_t)
  input wire logic [1:0] ilen_i, // Instruction length
  input wire logic jump_taken_i, // Jump condition met
  input wire logic [PC_W-1:0] dest_i, // Jump/call destination
  input wire logic [ROM_W-1:0] rom_data_i, // Program memory word
  input wire logic ram_we_i, // Data memory write
  input wire logic [RAM_AW-1:0] ram_waddr_i, // Data write index
  input wire logic [NIB_W-1:0] ram_wdata_i, // Data write nibble
  input wire logic [RAM_AW-1:0] ram_raddr_i, // Data read index
  input wire logic acc_we_i, // Accumulator write
  input wire logic [NIB_W-1:0] acc_wdata_i, // Accumulator data
  input wire logic [7:0] ctrl0_i, // First control register
  output logic [PC_W-1:0] rom_addr_o, // Program fetch address
  output logic [PC_W-1:0] table_read_pointer_o, // Table address
  output logic [ROM_W-1:0] rom_word_o, // Captured program word
  output logic [NIB_W-1:0] ram_rdata_o, // Data read nibble
  output logic [PC_W-1:0] return_address_o, // Return register
  output logic call_depth_o, // Call depth pointer
  output logic sys_reset_o, // Depth fault reset
  output logic [NIB_W-1:0] acc_o // Accumulator
);
  logic [2:0] ra_hi_reg;
  logic [NIB_W-1:0] acc_reg;
  logic [ROM_W-1:0] rom_word_reg;
  logic save;
  logic [7:0] first_pair;
  logic [7:0] last_pair;
  logic ra_seen_reg;

  // Data writes to the shared words clear the upper return bits
  wire shared_touch = ram_we_i && (ram_waddr_i == RAM_LAST_LO || ram_waddr_i == RAM_LAST_HI);
  wire [PC_W-1:0] return_address_register = {ra_hi_reg, last_pair};

  cps_sequencer #(.ROM_TOP(ROM_TOP)) u_seq (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .exec_i(exec_i),
    .op_i(op_i),
    .ilen_i(ilen_i),
    .jump_taken_i(jump_taken_i),
    .dest_i(dest_i),
    .ra_i(return_address_register),
    .pc_o(rom_addr_o),
    .depth_o(call_depth_o),
    .sys_reset_o(sys_reset_o),
    .save_o(save)
  );

  cps_data_ram u_ram (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .we_i(ram_we_i),
    .waddr_i(ram_waddr_i),
    .wdata_i(ram_wdata_i),
    .ra_we_i(save),
    .ra_wdata_i(rom_addr_o[7:0]),
    .raddr_i(ram_raddr_i),
    .rdata_o(ram_rdata_o),
    .first_pair_o(first_pair),
    .last_pair_o(last_pair)
  );

  // Upper return bits keep value over reset and return
  always_ff @(posedge mclk_i) begin
    if (save) begin
      ra_hi_reg <= rom_addr_o[10:8];
    end else if (shared_touch) begin
      ra_hi_reg <= 3'h0;
    end
  end

  // Check helper only: return contents are unknown until the first save
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ra_seen_reg <= 1'b0;
    end else if (save) begin
      ra_seen_reg <= 1'b1;
    end
  end

  // No reset: contents stay undefined until first write
  always_ff @(posedge mclk_i) begin
    if (acc_we_i) begin
      acc_reg <= acc_wdata_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    rom_word_reg <= rom_data_i;
  end

  // First pair clears on reset so the pointer's low byte reads zero afterwards
  assign table_read_pointer_o = {ctrl0_i[CTRL0_TPTR_LSB+2:CTRL0_TPTR_LSB], first_pair};
  assign return_address_o = return_address_register;
  assign acc_o = acc_reg;
  assign rom_word_o = rom_word_reg;

  property p_ra_keep;
    @(posedge mclk_i) (ra_seen_reg && !save && !shared_touch) |=> $stable(return_address_register);
  endproperty
  a_ra_keep: assert property (p_ra_keep) else $error("return register changed");
  property p_tbl_reset;
    @(posedge mclk_i) (rst_i && ctrl0_i[CTRL0_TPTR_LSB+2:CTRL0_TPTR_LSB] == 3'h0) |=>
      table_read_pointer_o[7:0] == 8'h00;
  endproperty
  a_tbl_reset: assert property (p_tbl_reset) else $error("table pointer not zero");
endmodule // cps_program_core

// File: sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cps_pkg::*;
  logic mclk_i = 1'b0, rst_i = 1'b1, exec_i = 1'b0, jump_taken_i = 1'b0;
  logic ram_we_i = 1'b0, acc_we_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [1:0] ilen_i = 2'h1;
  logic [PC_W-1:0] dest_i = 11'h000;
  logic [ROM_W-1:0] rom_data_i = 10'h000;
  logic [RAM_AW-1:0] ram_waddr_i = 5'h00, ram_raddr_i = 5'h00;
  logic [NIB_W-1:0] ram_wdata_i = 4'h0, acc_wdata_i = 4'h0;
  // Pointer bits of the control register are clear while the first reset is applied
  logic [7:0] ctrl0_i = 8'h0F;
  logic [PC_W-1:0] rom_addr_o, table_read_pointer_o, return_address_o;
  logic [ROM_W-1:0] rom_word_o;
  logic [NIB_W-1:0] ram_rdata_o, acc_o;
  logic call_depth_o, sys_reset_o;
  int miscompares = 0, check_count = 0;
  logic [31:0] seed = 32'h12E5160B;
  logic [31:0] r;
  logic [10:0] exp_pc;
  logic [1:0] l;
  logic pulse;

  cps_program_core uut (.mclk_i(mclk_i), .rst_i(rst_i), .exec_i(exec_i), .op_i(op_i),
    .ilen_i(ilen_i), .jump_taken_i(jump_taken_i), .dest_i(dest_i), .rom_data_i(rom_data_i),
    .ram_we_i(ram_we_i), .ram_waddr_i(ram_waddr_i), .ram_wdata_i(ram_wdata_i),
    .ram_raddr_i(ram_raddr_i), .acc_we_i(acc_we_i), .acc_wdata_i(acc_wdata_i),
    .ctrl0_i(ctrl0_i), .rom_addr_o(rom_addr_o), .table_read_pointer_o(table_read_pointer_o),
    .rom_word_o(rom_word_o), .ram_rdata_o(ram_rdata_o), .return_address_o(return_address_o),
    .call_depth_o(call_depth_o), .sys_reset_o(sys_reset_o), .acc_o(acc_o));

  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Addresses past the populated area or inside the test area fold to zero
  function logic [10:0] fold(input logic [11:0] s);
    return (s > {1'b0, ROM_TOP_DEFAULT}) ? PC_RESET : s[10:0];
  endfunction

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task step(input cps_op_t op, input logic [1:0] il, input logic tk, input logic [10:0] d);
    logic [9:0] w;
    logic [31:0] t;
    t = rnd();
    w = t[9:0];
    @(posedge mclk_i);
    exec_i <= 1'b1;
    op_i <= op;
    ilen_i <= il;
    jump_taken_i <= tk;
    dest_i <= d;
    rom_data_i <= w;
    @(posedge mclk_i);
    exec_i <= 1'b0;
    #1;
    check("rom_word", rom_word_o, w);
  endtask

  task rd(input logic [4:0] a, input logic [3:0] e);
    @(posedge mclk_i);
    ram_raddr_i <= a;
    @(posedge mclk_i);
    #1;
    check("ram_rdata", ram_rdata_o, e);
  endtask

  task wr(input logic [4:0] a, input logic [3:0] d);
    @(posedge mclk_i);
    ram_we_i <= 1'b1;
    ram_waddr_i <= a;
    ram_wdata_i <= d;
    @(posedge mclk_i);
    ram_we_i <= 1'b0;
    rd(a, d);
  endtask

  task fault_seen();
    pulse = (sys_reset_o === 1'b1);
    @(posedge mclk_i);
    #1;
    pulse = pulse | (sys_reset_o === 1'b1);
    check("fault_pulse", pulse, 1);
    check("fault_pc", rom_addr_o, 0);
    check("fault_depth", call_depth_o, 0);
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    #1;
    check("pc_rst", rom_addr_o, 0);
    check("depth_rst", call_depth_o, 0);
    check("tptr_rst", table_read_pointer_o, 11'h000);
    $display("test reset done");
    exp_pc = 11'h000;
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      l = (r[1:0] == 2'h0) ? 2'h1 : r[1:0];
      if (r[2]) step(CPS_OP_JUMP, l, r[3], r[14:4]);
      else step(CPS_OP_NEXT, l, 1'b0, r[14:4]);
      exp_pc = (r[2] && r[3]) ? fold({1'b0, r[14:4]}) : fold({1'b0, exp_pc} + l);
      check("pc_seq", rom_addr_o, exp_pc);
    end
    step(CPS_OP_JUMP, 2'h1, 1'b1, 11'h7E8);
    step(CPS_OP_NEXT, 2'h1, 1'b0, 11'h000);
    check("pc_top", rom_addr_o, 11'h7E9);
    step(CPS_OP_NEXT, 2'h1, 1'b0, 11'h000);
    check("pc_wrap", rom_addr_o, 0);
    step(CPS_OP_JUMP, 2'h1, 1'b1, 11'h7EA);
    check("pc_test_area", rom_addr_o, 0);
    $display("test sequencing done");
    step(CPS_OP_JUMP, 2'h2, 1'b1, 11'h5A3);
    step(CPS_OP_CALL, 2'h2, 1'b0, 11'h123);
    check("call_pc", rom_addr_o, 11'h123);
    check("call_depth", call_depth_o, 1);
    check("call_ra", return_address_o, 11'h5A3);
    step(CPS_OP_RET, 2'h1, 1'b0, 11'h000);
    check("ret_pc", rom_addr_o, 11'h5A3);
    check("ret_depth", call_depth_o, 0);
    check("ret_ra", return_address_o, 11'h5A3);
    step(CPS_OP_RET, 2'h1, 1'b0, 11'h000);
    fault_seen();
    step(CPS_OP_CALL, 2'h2, 1'b0, 11'h055);
    step(CPS_OP_CALL, 2'h2, 1'b0, 11'h066);
    fault_seen();
    $display("test call depth done");
    step(CPS_OP_JUMP, 2'h2, 1'b1, 11'h6C4);
    step(CPS_OP_CALL, 2'h2, 1'b0, 11'h010);
    step(CPS_OP_RET, 2'h1, 1'b0, 11'h000);
    wr(5'h0F, 4'h7);
    wr(5'h1F, 4'hE);
    check("ra_shared", return_address_o, 11'h0E7);
    r = rnd();
    wr(5'h00, r[3:0]);
    wr(5'h10, r[7:4]);
    @(posedge mclk_i);
    ctrl0_i <= r[15:8];
    @(posedge mclk_i);
    #1;
    check("tptr", table_read_pointer_o, {r[14:12], r[7:0]});
    for (int i = 1; i < 15; i++) wr(i[4:0], 4'(rnd()));
    wr(5'h05, 4'h9);
    @(posedge mclk_i);
    acc_we_i <= 1'b1;
    acc_wdata_i <= 4'hA;
    @(posedge mclk_i);
    acc_we_i <= 1'b0;
    #1;
    check("acc", acc_o, 4'hA);
    $display("test data memory done");
    @(posedge mclk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    #1;
    check("pc_rst2", rom_addr_o, 0);
    check("depth_rst2", call_depth_o, 0);
    check("ra_keep", return_address_o, 11'h0E7);
    check("acc_keep", acc_o, 4'hA);
    check("tptr_rst2", table_read_pointer_o, {r[14:12], 8'h00});
    rd(5'h00, 4'h0);
    rd(5'h10, 4'h0);
    rd(5'h05, 4'h9);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // tb_top
